/* File: src/dds_phase_core_clock_select.sv */
// Phase accumulator, cosine mapping, clock source selection and serial port.
// Assumes all serial pins, update strobe and mode pin are asynchronous to sys_clk.
// Operation
// - Tuning increment accumulates into 32-bit phase, wrapping modulo two to thirty-two.
// - Increment is unsigned; values above half alias below Nyquist naturally.
// - Zero increment holds the present phase rather than returning to zero.
// - Clear control bit forces the accumulated phase to zero while active.
// - Active clear resets to one, buffer to zero, until first update.
// - Only the 19 top phase bits feed the cosine mapping.
// - Truncated phase maps through cosine to a 10-bit converter code.
// - Mode pin high enables crystal oscillator as reference source.
// - Mode pin low disables oscillator and buffer, ignores clock gate bit.
// - In oscillator mode, gate bit high stops the core clock.
// - Second control bit one enables the crystal-out buffer.
// - Multiplier field 04h to 14h sets PLL multiplication by that value.
// - Multiplier outside 4 to 20 bypasses and powers down the PLL.
// - Multiplier field steers the PLL regardless of the gate bit.
// - Serial port supports MSB-first and LSB-first order by configuration.
// - Serial port works two-wire bidirectional or three-wire split data.
// - Every configuration register is readable and writable over serial.
// - Serial transfers are honoured only while chip select is low.
// - Resync input high aborts the transfer; new one starts after release.
`timescale 1ns/1ps
module dds_phase_core_clock_select
  import dds_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic chipSelectN,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output logic serialDataOutput,
  input wire logic portResync,
  input wire logic ioUpdate,
  input wire logic oscillatorModePin,
  output logic [dds_pkg::DAC_W-1:0] dacCode,
  output logic [dds_pkg::PHASE_W-1:0] truncatedPhase,
  output logic oscEnable,
  output logic xtalBufEnable,
  output logic synthCoreClockStopped,
  output logic pllEnable,
  output logic [4:0] pllMultiplier
);
  import dds_pkg::*;

  // Two-flop synchronisers; syncA_r is read only by syncB_r
  logic [5:0] syncA_r, syncB_r, syncC_r;
  logic sclkS, csNS, dinS, resyncS, updS, oscModeS, sclkRise, sclkFall, updRise;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      syncA_r <= 6'h03;
      syncB_r <= 6'h03;
      syncC_r <= 6'h03;
    end
    else if (ce)
    begin
      syncA_r <= {oscillatorModePin, ioUpdate, portResync, sdioIn, chipSelectN, sclk};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  assign sclkS = syncB_r[0];
  assign csNS = syncB_r[1];
  assign dinS = syncB_r[2];
  assign resyncS = syncB_r[3];
  assign updS = syncB_r[4];
  assign oscModeS = syncB_r[5];
  assign sclkRise = sclkS & ~syncC_r[0];
  assign sclkFall = ~sclkS & syncC_r[0];
  assign updRise = updS & ~syncC_r[4];

  // Active configuration, loaded from buffers on the update strobe
  logic [31:0] ctrl1_r, ctrl1_nxt, tune_r, tune_nxt;
  logic [23:0] ctrl2_r, ctrl2_nxt;
  logic [31:0] ctrl1Buf_r, ctrl1Buf_nxt, tuneBuf_r, tuneBuf_nxt;
  logic [23:0] ctrl2Buf_r, ctrl2Buf_nxt;
  logic lsbFirst, sdioOnly;

  assign lsbFirst = ctrl1_r[LSB_FIRST_BIT];
  assign sdioOnly = ctrl1_r[SDIO_ONLY_BIT];

  // Serial slave
  ser_state_t state_r, state_nxt;
  logic [5:0] cnt_r, cnt_nxt, len_r, len_nxt, idx;
  logic [7:0] ins_r, ins_nxt;
  logic [31:0] rx_r, rx_nxt, tx_r, tx_nxt, wordIn;
  logic isRead_r, isRead_nxt, sdo_r, sdo_nxt;
  logic [4:0] addr_r, addr_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    ins_nxt = ins_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    isRead_nxt = isRead_r;
    sdo_nxt = sdo_r;
    addr_nxt = addr_r;
    ctrl1Buf_nxt = ctrl1Buf_r;
    ctrl2Buf_nxt = ctrl2Buf_r;
    tuneBuf_nxt = tuneBuf_r;
    wordIn = 32'h0000_0000;
    idx = lsbFirst ? cnt_r : len_r - 6'h01 - cnt_r;
    if (csNS || resyncS)
    begin
      state_nxt = SER_IDLE;
      cnt_nxt = 6'h00;
      sdo_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        SER_IDLE:
        begin
          state_nxt = SER_INSTR;
          cnt_nxt = 6'h00;
        end
        SER_INSTR:
        begin
          if (sclkRise)
          begin
            ins_nxt = lsbFirst ? {dinS, ins_r[7:1]} : {ins_r[6:0], dinS};
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == INSTR_BITS - 6'h01)
            begin
              state_nxt = SER_DATA;
              cnt_nxt = 6'h00;
              isRead_nxt = ins_nxt[READ_BIT];
              addr_nxt = ins_nxt[4:0];
              case (ins_nxt[4:0])
                ADDR_CTRL1:
                begin
                  len_nxt = LEN_CTRL1;
                  tx_nxt = ctrl1Buf_r;
                end
                ADDR_CTRL2:
                begin
                  len_nxt = LEN_CTRL2;
                  tx_nxt = {8'h00, ctrl2Buf_r};
                end
                ADDR_TUNE:
                begin
                  len_nxt = LEN_TUNE;
                  tx_nxt = tuneBuf_r;
                end
                default:
                begin
                  len_nxt = LEN_OTHER;
                  tx_nxt = 32'h0000_0000;
                end
              endcase
            end
          end
        end
        SER_DATA:
        begin
          // Read data changes on the falling edge so the master samples on the rising one
          if (sclkFall && isRead_r)
          begin
            sdo_nxt = tx_r[idx[4:0]];
          end
          if (sclkRise)
          begin
            rx_nxt = lsbFirst ? {dinS, rx_r[31:1]} : {rx_r[30:0], dinS};
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == len_r - 6'h01)
            begin
              state_nxt = SER_INSTR;
              cnt_nxt = 6'h00;
              wordIn = lsbFirst ? rx_nxt >> (LEN_WORD - len_r) : rx_nxt;
              if (!isRead_r)
              begin
                case (addr_r)
                  ADDR_CTRL1: ctrl1Buf_nxt = wordIn;
                  ADDR_CTRL2: ctrl2Buf_nxt = wordIn[23:0];
                  ADDR_TUNE: tuneBuf_nxt = wordIn;
                  default: ctrl1Buf_nxt = ctrl1Buf_r;
                endcase
              end
            end
          end
        end
        default:
        begin
          state_nxt = SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_r <= SER_IDLE;
      cnt_r <= 6'h00;
      len_r <= LEN_OTHER;
      ins_r <= 8'h00;
      rx_r <= 32'h0000_0000;
      tx_r <= 32'h0000_0000;
      isRead_r <= 1'b0;
      sdo_r <= 1'b0;
      addr_r <= 5'h00;
      ctrl1Buf_r <= CTRL1_BUF_RST;
      ctrl2Buf_r <= CTRL2_RST;
      tuneBuf_r <= TUNE_RST;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      ins_r <= ins_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      isRead_r <= isRead_nxt;
      sdo_r <= sdo_nxt;
      addr_r <= addr_nxt;
      ctrl1Buf_r <= ctrl1Buf_nxt;
      ctrl2Buf_r <= ctrl2Buf_nxt;
      tuneBuf_r <= tuneBuf_nxt;
    end
  end

  // Two-wire mode turns the data pin round only while read data is shifted out
  assign sdioOut = sdo_r;
  assign sdioOe = (state_r == SER_DATA) && isRead_r && !sdioOnly && !csNS;
  assign serialDataOutput = sdo_r;

  // Core: accumulator, cosine mapping and clock selection
  logic [31:0] acc_r, acc_nxt;
  logic [9:0] dac_r, dac_nxt;
  logic [18:0] ph_r, ph_nxt, shifted, inv;
  logic [36:0] prod;
  logic [9:0] mag10;
  logic [8:0] mag;
  logic [4:0] mult;
  logic oscEn_r, oscEn_nxt, xbuf_r, xbuf_nxt, stop_r, stop_nxt, pllEn_r, pllEn_nxt;
  logic [4:0] mult_r, mult_nxt;

  assign mult = ctrl2_r[MULT_HI:MULT_LO];

  always_comb
  begin
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    tune_nxt = tune_r;
    if (updRise)
    begin
      ctrl1_nxt = ctrl1Buf_r;
      ctrl2_nxt = ctrl2Buf_r;
      tune_nxt = tuneBuf_r;
    end
    oscEn_nxt = oscModeS;
    xbuf_nxt = oscModeS & ctrl2_r[XBUF_BIT];
    stop_nxt = oscModeS & ctrl2_r[GATE_BIT];
    pllEn_nxt = (mult >= MULT_MIN) && (mult <= MULT_MAX);
    mult_nxt = pllEn_nxt ? mult : 5'h01;
    acc_nxt = acc_r;
    ph_nxt = ph_r;
    dac_nxt = dac_r;
    // Approximation 4u(1-u) of the half sine; peak error near 5.6 percent
    shifted = ph_r + QUARTER_TURN;
    inv = HALF_TURN - {1'b0, shifted[17:0]};
    prod = {19'h0_0000, shifted[17:0]} * {18'h0_0000, inv};
    mag10 = prod[34:25];
    mag = mag10[9] ? MAG_MAX : mag10[8:0];
    if (!stop_r)
    begin
      if (ctrl1_r[CLR_BIT])
      begin
        acc_nxt = 32'h0000_0000;
      end
      else
      begin
        acc_nxt = acc_r + tune_r;
      end
      ph_nxt = acc_nxt[ACC_W-1:ACC_W-PHASE_W];
      dac_nxt = shifted[18] ? DAC_MID - {1'b0, mag} : DAC_MID + {1'b0, mag};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrl1_r <= CTRL1_RST;
      ctrl2_r <= CTRL2_RST;
      tune_r <= TUNE_RST;
      acc_r <= 32'h0000_0000;
      ph_r <= 19'h0_0000;
      dac_r <= 10'h000;
      oscEn_r <= 1'b0;
      xbuf_r <= 1'b0;
      stop_r <= 1'b0;
      pllEn_r <= 1'b0;
      mult_r <= 5'h01;
    end
    else if (ce)
    begin
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      tune_r <= tune_nxt;
      acc_r <= acc_nxt;
      ph_r <= ph_nxt;
      dac_r <= dac_nxt;
      oscEn_r <= oscEn_nxt;
      xbuf_r <= xbuf_nxt;
      stop_r <= stop_nxt;
      pllEn_r <= pllEn_nxt;
      mult_r <= mult_nxt;
    end
  end

  assign dacCode = dac_r;
  assign truncatedPhase = ph_r;
  assign oscEnable = oscEn_r;
  assign xtalBufEnable = xbuf_r;
  assign synthCoreClockStopped = stop_r;
  assign pllEnable = pllEn_r;
  assign pllMultiplier = mult_r;
endmodule

/* File: src/dds_pkg.sv */
// Constants, register layout and state codes of the synthesis core.
// Assumes one 125 MHz system clock and a serial configuration port.
package dds_pkg;
  localparam int ACC_W = 32;
  localparam int PHASE_W = 19;
  localparam int DAC_W = 10;
  localparam real CLK_PERIOD_NS = 8.0;
  // Serial addresses and transfer lengths in bits
  localparam logic [4:0] ADDR_CTRL1 = 5'h00;
  localparam logic [4:0] ADDR_CTRL2 = 5'h01;
  localparam logic [4:0] ADDR_TUNE = 5'h04;
  localparam logic [5:0] LEN_CTRL1 = 6'h20;
  localparam logic [5:0] LEN_CTRL2 = 6'h18;
  localparam logic [5:0] LEN_TUNE = 6'h20;
  localparam logic [5:0] LEN_OTHER = 6'h08;
  localparam logic [5:0] LEN_WORD = 6'h20;
  localparam logic [5:0] INSTR_BITS = 6'h08;
  localparam int READ_BIT = 7;
  // First control register fields
  localparam int LSB_FIRST_BIT = 8;
  localparam int SDIO_ONLY_BIT = 9;
  localparam int CLR_BIT = 10;
  // Second control register fields
  localparam int GATE_BIT = 0;
  localparam int XBUF_BIT = 1;
  localparam int MULT_LO = 3;
  localparam int MULT_HI = 7;
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;
  // Reset values: active clear set, its buffered copy cleared
  localparam logic [31:0] CTRL1_RST = 32'h0000_0400;
  localparam logic [31:0] CTRL1_BUF_RST = 32'h0000_0000;
  localparam logic [23:0] CTRL2_RST = 24'h00_0000;
  localparam logic [31:0] TUNE_RST = 32'h0000_0000;
  localparam logic [18:0] QUARTER_TURN = 19'h2_0000;
  localparam logic [18:0] HALF_TURN = 19'h4_0000;
  localparam logic [9:0] DAC_MID = 10'h200;
  localparam logic [8:0] MAG_MAX = 9'h1FF;
  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_INSTR = 3'b010,
    SER_DATA = 3'b100
  } ser_state_t;
endpackage

/* File: tb/ser_master.sv */
// Serial master model standing in for the configuring microcontroller.
// Assumes sys_clk of the core; pins move on its falling edge only.
`timescale 1ns/1ps
module ser_master #(parameter int HALF = 6)
(
  input wire logic clk,
  input wire logic lsb,
  input wire logic twoWire,
  output logic sclk,
  output logic chipSelectN,
  output logic sdioLine,
  input wire logic sdioOut,
  input wire logic sdioOe,
  input wire logic serialDataOutput
);
  logic drv;
  // Shared data pin: whoever enables wins, else our own level
  assign sdioLine = sdioOe ? sdioOut : drv;
  initial
  begin
    sclk = 1'b1;
    chipSelectN = 1'b1;
    drv = 1'b0;
  end
  task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, input int n,
    output logic [31:0] rd);
    int k;
    rd = '0;
    chipSelectN = 1'b0;
    for (int i = 0; i < 8 + n; i++)
    begin
      k = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : n + 7 - i);
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
      // Released line toggles so a stale value never reads as data
      drv = (i < 8) ? ins[k] : (ins[7] ? ~drv : wd[k]);
      repeat (HALF) @(negedge clk);
      if (i >= 8)
        rd[k] = twoWire ? sdioLine : serialDataOutput;
      sclk = 1'b1;
    end
    repeat (HALF) @(negedge clk);
    chipSelectN = 1'b1;
    drv = ~drv;
    // Idle gap so back-to-back frames show chip select high between them
    repeat (HALF) @(negedge clk);
  endtask
endmodule

/* File: tb/dds_phase_core_clock_select_asserts.sv */
// Port-level checks of the synthesis core.
// Assumes one sys_clk domain and synchronous srst; attached by bind.
`timescale 1ns/1ps
module dds_phase_core_clock_select_asserts
  import dds_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic chipSelectN,
  input wire logic portResync,
  input wire logic ioUpdate,
  input wire logic sdioOut,
  input wire logic sdioOe,
  input wire logic serialDataOutput,
  input wire logic [dds_pkg::DAC_W-1:0] dacCode,
  input wire logic [dds_pkg::PHASE_W-1:0] truncatedPhase,
  input wire logic oscEnable,
  input wire logic xtalBufEnable,
  input wire logic synthCoreClockStopped,
  input wire logic pllEnable,
  input wire logic [4:0] pllMultiplier
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic updSeen;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      updSeen <= 1'b0;
    else if (ioUpdate)
      updSeen <= 1'b1;
  end
  sequence csIdle;
    chipSelectN [*6];
  endsequence
  sequence resyncHeld;
    portResync [*5];
  endsequence
  sequence resetDone;
    $fell(srst) ##0 $past(ce);
  endsequence
  AST_RESET_STATE: assert property (resetDone |-> truncatedPhase == '0 && dacCode == '0
    && pllMultiplier == 5'h01 && !sdioOe) else $error("bad state after reset");
  AST_CLEAR_AT_START: assert property (!updSeen |-> truncatedPhase == '0)
    else $error("phase moved before first update");
  AST_PLL_RANGE: assert property (pllEnable |-> pllMultiplier >= MULT_MIN
    && pllMultiplier <= MULT_MAX) else $error("multiplier out of range");
  AST_PLL_BYPASS: assert property (!pllEnable |-> pllMultiplier == 5'h01)
    else $error("bypass multiplier not one");
  AST_MODE_LOW: assert property (!oscEnable |-> !xtalBufEnable && !synthCoreClockStopped)
    else $error("gate or buffer active in external mode");
  AST_STOP_FREEZE: assert property (synthCoreClockStopped |=> $stable(truncatedPhase)
    && $stable(dacCode)) else $error("core moved while stopped");
  AST_CE_FREEZE: assert property (!ce |=> $stable(truncatedPhase))
    else $error("phase moved with enable low");
  AST_SDIO_NEEDS_CS: assert property (sdioOe |-> !$past(chipSelectN, 2))
    else $error("data pin driven without chip select");
  AST_CS_IDLE: assert property (csIdle |-> !sdioOe)
    else $error("driving with chip select high");
  AST_RESYNC_IDLE: assert property (resyncHeld |-> !sdioOe)
    else $error("driving during resync");
endmodule
bind dds_phase_core_clock_select dds_phase_core_clock_select_asserts chk (.sys_clk, .srst,
  .ce, .chipSelectN, .portResync, .ioUpdate, .sdioOut, .sdioOe, .serialDataOutput,
  .dacCode, .truncatedPhase, .oscEnable, .xtalBufEnable, .synthCoreClockStopped,
  .pllEnable, .pllMultiplier);

/* File: tb/dds_phase_core_clock_select_tb.sv */
// Self-checking bench: serial master model, update strobe and mode pin.
// Assumes the core, its checker and the master model are compiled first.
`timescale 1ns/1ps
module dds_phase_core_clock_select_tb;
  import dds_pkg::*;
  logic sys_clk, srst, ce, sclk, chipSelectN, sdioLine, sdioOut, sdioOe;
  logic serialDataOutput, portResync, ioUpdate, oscillatorModePin, oscEnable;
  logic xtalBufEnable, synthCoreClockStopped, pllEnable, lsb, twoWire, en;
  logic [4:0] pllMultiplier;
  logic [DAC_W-1:0] dacCode;
  logic [PHASE_W-1:0] truncatedPhase;
  logic [31:0] r;
  logic [4:0] mults [4] = '{5'h03, 5'h04, 5'h14, 5'h15};
  int nErrors = 0;
  int nTests = 0;
  dds_phase_core_clock_select uut (.sys_clk, .srst, .ce, .sclk, .chipSelectN,
    .sdioIn(sdioLine), .sdioOut, .sdioOe, .serialDataOutput, .portResync, .ioUpdate,
    .oscillatorModePin, .dacCode, .truncatedPhase, .oscEnable, .xtalBufEnable,
    .synthCoreClockStopped, .pllEnable, .pllMultiplier);
  ser_master #(.HALF(6)) m (.clk(sys_clk), .lsb, .twoWire, .sclk, .chipSelectN,
    .sdioLine, .sdioOut, .sdioOe, .serialDataOutput);
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic endOfTest();
    $display("checks %0d errors %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
    nTests++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", what, e, s);
      nErrors++;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input int n);
    m.xfer({3'b000, a}, d, n, r);
  endtask
  task automatic rdc(input logic [4:0] a, input int n, input logic [31:0] e);
    m.xfer({3'b100, a}, 32'h0, n, r);
    cmp("readback", e, r);
  endtask
  task automatic upd();
    @(negedge sys_clk);
    ioUpdate = 1'b1;
    repeat (4) @(negedge sys_clk);
    ioUpdate = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic step(input int n, input logic [18:0] d);
    logic [18:0] p;
    @(negedge sys_clk);
    p = truncatedPhase;
    repeat (n) @(negedge sys_clk);
    cmp("phase step", {13'h0, d}, {13'h0, truncatedPhase - p});
  endtask
  task automatic clk(input logic [8:0] e);
    cmp("clock select", {23'h0, e}, {23'h0, oscEnable, xtalBufEnable,
      synthCoreClockStopped, pllEnable, pllMultiplier});
  endtask
  initial
  begin
    #500000;
    nErrors++;
    endOfTest();
  end
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    portResync = 1'b0;
    ioUpdate = 1'b0;
    oscillatorModePin = 1'b0;
    lsb = 1'b0;
    twoWire = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    repeat (6) @(negedge sys_clk);
    wr(ADDR_TUNE, 32'h0000_2000, 32);
    step(4, 19'h0);
    cmp("dac sign", 32'h1, {31'h0, dacCode[9]});
    wr(ADDR_CTRL1, 32'h0, 32);
    upd();
    step(1, 19'h1);
    ce = 1'b0;
    step(2, 19'h0);
    ce = 1'b1;
    wr(ADDR_TUNE, 32'h8000_0000, 32);
    upd();
    step(1, 19'h4_0000);
    wr(ADDR_TUNE, 32'hFFFF_E000, 32);
    upd();
    step(1, 19'h7_FFFF);
    wr(ADDR_TUNE, 32'h0000_1000, 32);
    upd();
    step(2, 19'h1);
    wr(ADDR_TUNE, 32'h0, 32);
    upd();
    step(3, 19'h0);
    cmp("held phase", 32'h1, {31'h0, truncatedPhase != '0});
    cmp("dac sign", {31'h0, truncatedPhase[18] ~^ truncatedPhase[17]}, {31'h0, dacCode[9]});
    wr(ADDR_TUNE, 32'h0000_2000, 32);
    wr(ADDR_CTRL1, 32'h0000_0400, 32);
    upd();
    cmp("cleared", 32'h0, {13'h0, truncatedPhase});
    rdc(ADDR_CTRL1, 32, 32'h0000_0400);
    rdc(ADDR_TUNE, 32, 32'h0000_2000);
    wr(5'h1F, 32'hA5, 8);
    rdc(5'h1F, 8, 32'h0);
    wr(ADDR_CTRL1, 32'h0, 32);
    oscillatorModePin = 1'b1;
    wr(ADDR_CTRL2, 32'h52, 24);
    upd();
    clk(9'h1AA);
    wr(ADDR_CTRL2, 32'h53, 24);
    upd();
    clk(9'h1EA);
    step(2, 19'h0);
    oscillatorModePin = 1'b0;
    repeat (8) @(negedge sys_clk);
    clk(9'h02A);
    step(1, 19'h1);
    // No lock wait: only the selection outputs are checked, never the multiplied clock
    foreach (mults[i])
    begin
      wr(ADDR_CTRL2, {24'h0, mults[i], 3'b000}, 24);
      upd();
      en = mults[i] >= MULT_MIN && mults[i] <= MULT_MAX;
      clk({3'b000, en, en ? mults[i] : 5'h01});
    end
    wr(ADDR_CTRL1, 32'h0000_0100, 32);
    upd();
    lsb = 1'b1;
    wr(ADDR_TUNE, 32'h1234_5678, 32);
    rdc(ADDR_TUNE, 32, 32'h1234_5678);
    // Abort a two-wire read in its data phase; the pin must be released
    fork
      m.xfer({3'b100, ADDR_TUNE}, 32'h0, 32, r);
      begin
        repeat (150) @(negedge sys_clk);
        portResync = 1'b1;
      end
    join
    portResync = 1'b0;
    wr(ADDR_CTRL1, 32'h0000_0200, 32);
    upd();
    lsb = 1'b0;
    twoWire = 1'b0;
    fork
      wr(ADDR_TUNE, 32'h0, 32);
      begin
        repeat (150) @(negedge sys_clk);
        portResync = 1'b1;
      end
    join
    portResync = 1'b0;
    repeat (4) @(negedge sys_clk);
    rdc(ADDR_TUNE, 32, 32'h1234_5678);
    endOfTest();
  end
endmodule
